/* clk_gate_pkg.sv */
// constants and types for peripheral clock gating and wake-up control
package clk_gate_pkg;

  // ---------------------------------------------------------------
  // cpu power states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN,
    ST_HALT,
    ST_SLEEP
  } power_state_t;

  // ---------------------------------------------------------------
  // synchroniser depth and reset values
  // ---------------------------------------------------------------
  localparam int   SYNC_STAGES   = 2;
  localparam logic CLK_ON_RESET  = 1'b1;
  localparam logic CLK_OFF_RESET = 1'b0;

endpackage

/* wake_sync.sv */
// two-flop synchroniser bank for wake-up requests
`timescale 1ns/10ps
module wake_sync #(
  parameter int WIDTH = 4
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  // requests
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  // ---------------------------------------------------------------
  // first stage feeds only the second stage
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // wake_sync

/* periph_clock_gating_wakeup.sv */
// peripheral clock gate and halt/sleep wake-up controller
`timescale 1ns/10ps
module periph_clock_gating_wakeup
  import clk_gate_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic reset_n,
  // cpu requests
  input  wire logic halt_req,
  input  wire logic sleep_req,
  // software clock settings
  input  wire logic pclk_enable,
  input  wire logic pclk_run_in_halt,
  input  wire logic rtc_running,
  input  wire logic low_speed_osc_periph,
  input  wire logic low_speed_osc_is_sysclk,
  // wake-up sources, may be asynchronous
  input  wire logic port_irq,
  input  wire logic onchip_debugger_break,
  input  wire logic rtc_irq,
  input  wire logic low_speed_osc_periph_irq,
  input  wire logic pclk_periph_irq,
  // clock enables out
  output logic      cpu_core_clock_en,
  output logic      pclk_gated_en,
  output logic      ungated_periph_en,
  output logic      low_speed_osc_en,
  output logic      high_speed_osc_a_en,
  output logic      high_speed_osc_b_en,
  // status
  output logic      halted,
  output logic      sleeping,
  output logic      wake_pulse
);

  import clk_gate_pkg::*;

  // ---------------------------------------------------------------
  // wake request synchronisation
  // ---------------------------------------------------------------
  logic [3:0] wake_raw;
  logic [3:0] wake_sync_w;

  assign wake_raw = {pclk_periph_irq, low_speed_osc_periph_irq, rtc_irq,
                     port_irq | onchip_debugger_break};

  wake_sync #(
    .WIDTH (4)
  ) u_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in (wake_raw),
    .sync_out (wake_sync_w)
  );

  wire port_wake = wake_sync_w[0];
  wire rtc_wake  = wake_sync_w[1];
  wire low_speed_osc_wake = wake_sync_w[2];
  wire pclk_wake = wake_sync_w[3];

  // ---------------------------------------------------------------
  // state and wake decode
  // ---------------------------------------------------------------
  power_state_t state_q;
  power_state_t state_d;
  logic         sleep_rtc_q;

  wire halt_wake  = port_wake
                  | (rtc_wake & rtc_running)
                  | (low_speed_osc_wake & low_speed_osc_periph
                     & low_speed_osc_is_sysclk)
                  | (pclk_wake & pclk_enable
                     & pclk_run_in_halt);
  // high-speed oscillators are down in sleep, so only port, debugger break and rtc remain
  wire sleep_wake = port_wake
                  | (rtc_wake & sleep_rtc_q);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_RUN:
        if (sleep_req)
          state_d = ST_SLEEP;
        else if (halt_req)
          state_d = ST_HALT;
      ST_HALT:
        if (halt_wake)
          state_d = ST_RUN;
      ST_SLEEP:
        if (sleep_wake)
          state_d = ST_RUN;
      default:
        state_d = ST_RUN;
    endcase
  end

  wire go_run = (state_q != ST_RUN) & (state_d == ST_RUN);
  wire in_run_d   = (state_d == ST_RUN);
  wire in_halt_d  = (state_d == ST_HALT);
  wire in_sleep_d = (state_d == ST_SLEEP);
  wire sleep_rtc_d = (state_q == ST_RUN) ? rtc_running : sleep_rtc_q;

  // ---------------------------------------------------------------
  // clock enable decode
  // ---------------------------------------------------------------
  // cpu clock stops in halt and sleep
  wire cpu_en_d  = in_run_d;
  // gated peripheral group; also stopped in sleep as its source halts
  wire pclk_en_d = pclk_enable & (in_run_d
                 | (in_halt_d & pclk_run_in_halt));
  // ungated group only loses its clock when all oscillators stop
  wire ung_en_d  = ~(in_sleep_d & ~sleep_rtc_d);
  wire low_speed_osc_en_d = ~in_sleep_d | sleep_rtc_d;
  wire osc3_en_d = ~in_sleep_d;

  // ---------------------------------------------------------------
  // registers; all outputs come straight from flops
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q             <= ST_RUN;
      sleep_rtc_q         <= CLK_OFF_RESET;
      cpu_core_clock_en   <= CLK_ON_RESET;
      pclk_gated_en       <= CLK_ON_RESET;
      ungated_periph_en   <= CLK_ON_RESET;
      low_speed_osc_en    <= CLK_ON_RESET;
      high_speed_osc_a_en <= CLK_ON_RESET;
      high_speed_osc_b_en <= CLK_ON_RESET;
      halted              <= CLK_OFF_RESET;
      sleeping            <= CLK_OFF_RESET;
      wake_pulse          <= CLK_OFF_RESET;
    end
    else
    begin
      state_q             <= state_d;
      sleep_rtc_q         <= sleep_rtc_d;
      cpu_core_clock_en   <= cpu_en_d;
      pclk_gated_en       <= pclk_en_d;
      ungated_periph_en   <= ung_en_d;
      low_speed_osc_en    <= low_speed_osc_en_d;
      high_speed_osc_a_en <= osc3_en_d;
      high_speed_osc_b_en <= osc3_en_d;
      halted              <= in_halt_d;
      sleeping            <= in_sleep_d;
      wake_pulse          <= go_run;
    end
  end

endmodule // periph_clock_gating_wakeup

/* gate_wake_monitor.sv */
// assertion checker for gating and wake-up
`timescale 1ns/10ps
module gate_wake_monitor (
  // clock, reset and inputs
  input wire logic clock, reset_n, halt_req, sleep_req, port_irq, rtc_irq,
  input wire logic onchip_debugger_break, low_speed_osc_periph_irq, pclk_periph_irq,
  // outputs
  input wire logic cpu_core_clock_en, pclk_gated_en, ungated_periph_en,
  input wire logic halted, sleeping, wake_pulse
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wire run = !halted && !sleeping;
  wire sw = port_irq || onchip_debugger_break || rtc_irq;
  // two sync flops: a wake lands three edges after its source
  wire src = sw || low_speed_osc_periph_irq || pclk_periph_irq;
  a_halt_entry: assert property (run && (halt_req || sleep_req) |=> !run)
    else $error("no stop");
  a_cpu_stop: assert property (!run |-> !cpu_core_clock_en)
    else $error("cpu runs");
  a_sleep_gate: assert property (sleeping |-> !pclk_gated_en)
    else $error("pclk on");
  a_ungated_on: assert property (!sleeping |-> ungated_periph_en)
    else $error("ungated off");
  a_port_wake: assert property ((!run && port_irq) [*3] |=> run)
    else $error("no port wake");
  a_wake_cause: assert property ($rose(run) |-> $past(src, 2))
    else $error("wake cause");
  a_sleep_src: assert property ($fell(sleeping) |-> $past(sw, 2))
    else $error("sleep wake");
  a_wake_pulse: assert property ($rose(run) |-> wake_pulse ##1 !wake_pulse)
    else $error("wake pulse");
  cover property (halted ##4 run);
  cover property (sleeping ##4 run);
  cover property (sleeping && !ungated_periph_en);
endmodule // gate_wake_monitor

bind periph_clock_gating_wakeup gate_wake_monitor mon (.*);

/* wake_source_model.sv */
// irq sources held until the cpu clock runs, as a handler clears them
`timescale 1ns/10ps
module wake_source_model (
  // clock, reset, pulses, acknowledge and levels
  input  wire logic       clock, reset_n, cpu_core_clock_en,
  input  wire logic [4:0] fire,
  output logic      [4:0] irq
);
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
      irq <= 5'h00;
    else
      irq <= fire | (irq & {5{!cpu_core_clock_en}});
endmodule // wake_source_model

/* testbench.sv */
// self-checking bench for gating and wake-up
`timescale 1ns/10ps
module testbench;
  logic clock, reset_n, halt_req, sleep_req, pclk_enable, pclk_run_in_halt;
  logic rtc_running, low_speed_osc_periph, low_speed_osc_is_sysclk, halted;
  logic cpu_core_clock_en, pclk_gated_en, ungated_periph_en, sleeping;
  logic low_speed_osc_en, high_speed_osc_a_en, high_speed_osc_b_en, wake_pulse;
  logic [4:0] fire, irq;
  logic [9:0] r;
  int checks, failures;
  // sleep, pclk on, pclk in halt, rtc, low_speed_osc periph, low_speed_osc sys, source, wake
  logic [9:0] rows [14] = '{10'h001, 10'h003, 10'h045, 10'h004, 10'h037,
    10'h026, 10'h189, 10'h108, 10'h201, 10'h203, 10'h245, 10'h204,
    10'h3B6, 10'h3B8};
  periph_clock_gating_wakeup dut (.*, .port_irq(irq[0]),
    .onchip_debugger_break(irq[1]), .rtc_irq(irq[2]),
    .low_speed_osc_periph_irq(irq[3]), .pclk_periph_irq(irq[4]));
  wake_source_model far (.*);
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input string what, input logic seen, input logic exp);
    checks++;
    failures += (seen !== exp);
    if (seen !== exp)
      $display("ERROR %s expected %b seen %b", what, exp, seen);
  endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    foreach (rows[i])
    begin
      r = rows[i];
      {reset_n, halt_req, sleep_req, fire, pclk_enable, pclk_run_in_halt,
        rtc_running, low_speed_osc_periph, low_speed_osc_is_sysclk} =
        {8'h00, r[8:4]};
      repeat (2) @(negedge clock);
      reset_n = 1'b1;
      @(negedge clock);
      chk("cpu after reset", cpu_core_clock_en, 1'b1);
      {halt_req, sleep_req} = {!r[9], r[9]};
      @(negedge clock);
      {halt_req, sleep_req} = 2'h0;
      chk("state", r[9] ? sleeping : halted, 1'b1);
      chk("pclk", pclk_gated_en, !r[9] & r[8] & r[7]);
      chk("cpu", cpu_core_clock_en, 1'b0);
      chk("ungated", ungated_periph_en, !(r[9] & !r[6]));
      chk("low osc", low_speed_osc_en, !r[9] | r[6]);
      chk("high osc a", high_speed_osc_a_en, !r[9]);
      chk("high osc b", high_speed_osc_b_en, !r[9]);
      fire[r[3:1]] = 1'b1;
      @(negedge clock);
      fire = 5'h00;
      repeat (3) @(negedge clock);
      chk("wake", wake_pulse, r[0]);
      chk("cpu back", cpu_core_clock_en, r[0]);
      // stop again in the first cycle back, or with no request stay halted or asleep where the source was ignored
      halt_req = r[0];
      @(negedge clock);
      chk("halted", halted, r[0] | !r[9]);
    end
    give_verdict();
  end
endmodule // testbench
